// ==== crvt_defines.svh ====
// register indices, field positions and reset values of the vertical timing block
`ifndef CRVT_DEFINES_SVH
`define CRVT_DEFINES_SVH

// data port indices
`define CRVT_IDX_OVERFLOW       8'h07
`define CRVT_IDX_PROTECT_LAST   8'h07
`define CRVT_IDX_CURSOR_HIGH    8'h0E
`define CRVT_IDX_CURSOR_LOW     8'h0F
`define CRVT_IDX_RETRACE_START  8'h10
`define CRVT_IDX_RETRACE_END    8'h11
`define CRVT_IDX_DISPLAY_END    8'h12
`define CRVT_IDX_REPAINT4       8'h1A

// retrace end control fields
`define CRVT_REC_LOCK_BIT       7
`define CRVT_REC_RSV_BIT        6
`define CRVT_REC_MASK_N_BIT     5
`define CRVT_REC_CLEAR_N_BIT    4
`define CRVT_REC_WIDTH_MSB      3

// overflow fields
`define CRVT_OVF_VRS8_BIT       2
`define CRVT_OVF_VRS9_BIT       7
`define CRVT_OVF_VDE8_BIT       1
`define CRVT_OVF_VDE9_BIT       6
`define CRVT_OVF_FREE_MASK      8'h10

// repaint control 4 fields
`define CRVT_RC4_VRS10_BIT      2
`define CRVT_RC4_VDE10_BIT      1

// status register zero
`define CRVT_ST0_IRQ_BIT        7

// reset values
`define CRVT_REC_RESET          8'h10
`define CRVT_REG_RESET          8'h00
`define CRVT_INDEX_RESET        8'h00

`endif

// ==== crvt_pkg.sv ====
// types shared by the vertical timing block
package crvt_pkg;

    typedef enum logic [1:0] {
        CRVT_SEL_INDEX   = 2'b00,
        CRVT_SEL_DATA    = 2'b01,
        CRVT_SEL_STATUS0 = 2'b10,
        CRVT_SEL_NONE    = 2'b11
    } crvt_sel_e;

    typedef enum logic {
        CRVT_IRQ_IDLE      = 1'b0,
        CRVT_IRQ_WAIT_LINE = 1'b1
    } crvt_irq_state_e;

    typedef logic [10:0] crvt_line_t;

endpackage

// ==== crvt_vtiming.sv ====
// vertical retrace pulse and active display window
`include "crvt_defines.svh"

module crvt_vtiming
    import crvt_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // scan position
    input  wire logic       line_tick,
    input  wire crvt_line_t scan_line,
    // programmed values
    input  wire crvt_line_t retrace_start,
    input  wire logic [3:0] width_end,
    input  wire crvt_line_t disp_end,
    // timing outputs
    output logic            vretrace,
    output logic            display_active
);

    logic vretrace_reg;
    logic display_active_reg;

    // start wins on its own line, so equal low bits give a 16-line pulse
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            vretrace_reg <= 1'b0;
        end else if (line_tick) begin
            if (scan_line == retrace_start) begin
                vretrace_reg <= 1'b1;
            end else if (scan_line[3:0] == width_end) begin
                vretrace_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            display_active_reg <= 1'b0;
        end else begin
            display_active_reg <= (scan_line <= disp_end);
        end
    end

    assign vretrace       = vretrace_reg;
    assign display_active = display_active_reg;

endmodule

// ==== crvt_top.sv ====
// vertical timing, retrace interrupt and text cursor registers
`include "crvt_defines.svh"

module crvt_top
    import crvt_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // host index/data port
    input  wire logic [1:0]  io_sel,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    output logic             io_rdata_valid,
    // scan timing from the line counter
    input  wire logic        line_tick,
    input  wire crvt_line_t  scan_line,
    input  wire logic        vblank,
    // display context
    input  wire logic        graphics_mode,
    input  wire logic [19:0] screen_base,
    input  wire logic [15:0] char_index,
    // timing outputs
    output logic             vretrace,
    output logic             display_active,
    output logic             retrace_irq,
    // cursor outputs
    output logic      [19:0] cursor_addr,
    output logic             cursor_hit
);

    // host access decode
    logic        index_wr;
    logic        data_wr;
    logic        write_locked;
    logic [7:0]  index_reg;

    // register file
    logic [7:0]  cursor_position_high_reg;
    logic [7:0]  cursor_position_low_reg;
    logic [7:0]  retrace_start_low_reg;
    logic [7:0]  retrace_end_control_reg;
    logic [7:0]  display_end_low_reg;
    logic [7:0]  timing_overflow_reg;
    logic [7:0]  repaint4_reg;

    // derived fields
    logic [15:0] cursor_position;
    crvt_line_t  retrace_start;
    crvt_line_t  display_end;
    logic [3:0]  retrace_width_end;
    logic        timing_write_lock;
    logic        retrace_irq_mask_n;
    logic        retrace_irq_clear_n;

    // interrupt capture
    crvt_irq_state_e irq_state_reg;
    crvt_irq_state_e irq_state_next;
    logic        vblank_prev_reg;
    logic        vblank_rise;
    logic        retrace_event;
    logic        irq_flag_reg;
    logic        retrace_irq_reg;

    // read path
    logic [7:0]  read_mux;
    logic [7:0]  data_mux;
    logic [7:0]  io_rdata_reg;
    logic        io_rdata_valid_reg;

    // cursor path
    logic [19:0] cursor_addr_reg;
    logic        cursor_hit_reg;
    logic        vt_display_active;

    assign index_wr = io_wr && (crvt_sel_e'(io_sel) == CRVT_SEL_INDEX);
    assign data_wr  = io_wr && (crvt_sel_e'(io_sel) == CRVT_SEL_DATA);

    // lock covers the low timing indices only
    assign write_locked = timing_write_lock &&
                          (index_reg <= `CRVT_IDX_PROTECT_LAST);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            index_reg <= `CRVT_INDEX_RESET;
        end else if (index_wr) begin
            index_reg <= io_wdata;
        end
    end

    // cursor position bytes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cursor_position_high_reg <= `CRVT_REG_RESET;
        end else if (data_wr && index_reg == `CRVT_IDX_CURSOR_HIGH) begin
            cursor_position_high_reg <= io_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cursor_position_low_reg <= `CRVT_REG_RESET;
        end else if (data_wr && index_reg == `CRVT_IDX_CURSOR_LOW) begin
            cursor_position_low_reg <= io_wdata;
        end
    end

    // retrace start low byte
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            retrace_start_low_reg <= `CRVT_REG_RESET;
        end else if (data_wr && index_reg == `CRVT_IDX_RETRACE_START) begin
            retrace_start_low_reg <= io_wdata;
        end
    end

    // retrace end control keeps every bit, reserved bit 6 included
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            retrace_end_control_reg <= `CRVT_REC_RESET;
        end else if (data_wr && index_reg == `CRVT_IDX_RETRACE_END) begin
            retrace_end_control_reg <= io_wdata;
        end
    end

    // display end low byte
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            display_end_low_reg <= `CRVT_REG_RESET;
        end else if (data_wr && index_reg == `CRVT_IDX_DISPLAY_END) begin
            display_end_low_reg <= io_wdata;
        end
    end

    // overflow: bit 4 stays writable while the lock is on
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            timing_overflow_reg <= `CRVT_REG_RESET;
        end else if (data_wr && index_reg == `CRVT_IDX_OVERFLOW) begin
            if (write_locked) begin
                timing_overflow_reg <=
                    (timing_overflow_reg & ~`CRVT_OVF_FREE_MASK) |
                    (io_wdata & `CRVT_OVF_FREE_MASK);
            end else begin
                timing_overflow_reg <= io_wdata;
            end
        end
    end

    // repaint control 4 carries the top timing bits
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            repaint4_reg <= `CRVT_REG_RESET;
        end else if (data_wr && index_reg == `CRVT_IDX_REPAINT4) begin
            repaint4_reg <= io_wdata;
        end
    end

    // field assembly
    assign cursor_position = {cursor_position_high_reg,
                              cursor_position_low_reg};

    assign retrace_start = {repaint4_reg[`CRVT_RC4_VRS10_BIT],
                            timing_overflow_reg[`CRVT_OVF_VRS9_BIT],
                            timing_overflow_reg[`CRVT_OVF_VRS8_BIT],
                            retrace_start_low_reg};

    assign display_end = {repaint4_reg[`CRVT_RC4_VDE10_BIT],
                          timing_overflow_reg[`CRVT_OVF_VDE9_BIT],
                          timing_overflow_reg[`CRVT_OVF_VDE8_BIT],
                          display_end_low_reg};

    assign retrace_width_end   =
        retrace_end_control_reg[`CRVT_REC_WIDTH_MSB:0];
    assign timing_write_lock   =
        retrace_end_control_reg[`CRVT_REC_LOCK_BIT];
    assign retrace_irq_mask_n  =
        retrace_end_control_reg[`CRVT_REC_MASK_N_BIT];
    assign retrace_irq_clear_n =
        retrace_end_control_reg[`CRVT_REC_CLEAR_N_BIT];

    // retrace pulse and display window
    crvt_vtiming u_vtiming (
        .sys_clk        (sys_clk),
        .rst_n          (rst_n),
        .line_tick      (line_tick),
        .scan_line      (scan_line),
        .retrace_start  (retrace_start),
        .width_end      (retrace_width_end),
        .disp_end       (display_end),
        .vretrace       (vretrace),
        .display_active (vt_display_active)
    );

    assign display_active = vt_display_active;

    // vertical blanking edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            vblank_prev_reg <= 1'b0;
        end else begin
            vblank_prev_reg <= vblank;
        end
    end

    assign vblank_rise = vblank && !vblank_prev_reg;

    // wait for the line after blanking rises before recording
    always_comb begin
        irq_state_next = irq_state_reg;
        unique case (irq_state_reg)
            CRVT_IRQ_IDLE: begin
                if (vblank_rise) begin
                    irq_state_next = CRVT_IRQ_WAIT_LINE;
                end
            end
            CRVT_IRQ_WAIT_LINE: begin
                if (line_tick) begin
                    irq_state_next = CRVT_IRQ_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_state_reg <= CRVT_IRQ_IDLE;
        end else begin
            irq_state_reg <= irq_state_next;
        end
    end

    assign retrace_event = (irq_state_reg == CRVT_IRQ_WAIT_LINE) &&
                           line_tick;

    // clear is a level: an event under clear is dropped, not deferred
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_flag_reg <= 1'b0;
        end else if (!retrace_irq_clear_n) begin
            irq_flag_reg <= 1'b0;
        end else if (retrace_event) begin
            irq_flag_reg <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            retrace_irq_reg <= 1'b0;
        end else begin
            retrace_irq_reg <= irq_flag_reg && !retrace_irq_mask_n;
        end
    end

    assign retrace_irq = retrace_irq_reg;

    // data port read select; unmapped indices read zero
    always_comb begin
        data_mux = 8'h00;
        unique case (index_reg)
            `CRVT_IDX_OVERFLOW:      data_mux = timing_overflow_reg;
            `CRVT_IDX_CURSOR_HIGH:   data_mux = cursor_position_high_reg;
            `CRVT_IDX_CURSOR_LOW:    data_mux = cursor_position_low_reg;
            `CRVT_IDX_RETRACE_START: data_mux = retrace_start_low_reg;
            `CRVT_IDX_RETRACE_END:   data_mux = retrace_end_control_reg;
            `CRVT_IDX_DISPLAY_END:   data_mux = display_end_low_reg;
            `CRVT_IDX_REPAINT4:      data_mux = repaint4_reg;
            default:                 data_mux = 8'h00;
        endcase
    end

    always_comb begin
        read_mux = 8'h00;
        unique case (crvt_sel_e'(io_sel))
            CRVT_SEL_INDEX:   read_mux = index_reg;
            CRVT_SEL_DATA:    read_mux = data_mux;
            CRVT_SEL_STATUS0: begin
                read_mux[`CRVT_ST0_IRQ_BIT] = irq_flag_reg;
            end
            CRVT_SEL_NONE:    read_mux = 8'h00;
        endcase
    end

    // read data held until the next read
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            io_rdata_reg <= 8'h00;
        end else if (io_rd) begin
            io_rdata_reg <= read_mux;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            io_rdata_valid_reg <= 1'b0;
        end else begin
            io_rdata_valid_reg <= io_rd;
        end
    end

    assign io_rdata       = io_rdata_reg;
    assign io_rdata_valid = io_rdata_valid_reg;

    // two bytes per character cell; address wraps at 20 bits
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cursor_addr_reg <= 20'h0_0000;
        end else begin
            cursor_addr_reg <= screen_base +
                               {3'b000, cursor_position, 1'b0};
        end
    end

    // position zero matches the top-left cell of the frame
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cursor_hit_reg <= 1'b0;
        end else begin
            cursor_hit_reg <= !graphics_mode && vt_display_active &&
                              (char_index == cursor_position);
        end
    end

    assign cursor_addr = cursor_addr_reg;
    assign cursor_hit  = cursor_hit_reg;

endmodule

// ==== crvt_top_chk.sv ====
// concurrent checks on the ports of the vertical timing block
module crvt_top_chk
    import crvt_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // host port
    input wire logic [1:0]  io_sel,
    input wire logic        io_wr,
    input wire logic        io_rd,
    input wire logic [7:0]  io_wdata,
    input wire logic [7:0]  io_rdata,
    input wire logic        io_rdata_valid,
    // scan timing
    input wire logic        line_tick,
    input wire crvt_line_t  scan_line,
    input wire logic        vblank,
    // display context
    input wire logic        graphics_mode,
    input wire logic [19:0] screen_base,
    input wire logic [15:0] char_index,
    // outputs
    input wire logic        vretrace,
    input wire logic        display_active,
    input wire logic        retrace_irq,
    input wire logic [19:0] cursor_addr,
    input wire logic        cursor_hit
);
    timeunit 1ns;
    timeprecision 100ps;

    // shadow register file, so expectations lean on the design only through display_active
    logic [7:0]  idx_reg;
    logic [7:0]  rg [32];
    logic        mask_n;
    logic        clear_n;
    logic [3:0]  wend;
    logic [15:0] cpos;
    logic        hit_cond;
    crvt_line_t  vs;
    crvt_line_t  de;

    assign mask_n = rg[17][5];
    assign clear_n = rg[17][4];
    assign wend = rg[17][3:0];
    assign cpos = {rg[14], rg[15]};
    assign vs = {rg[26][2], rg[7][7], rg[7][2], rg[16]};
    assign de = {rg[26][1], rg[7][6], rg[7][1], rg[18]};
    assign hit_cond = !graphics_mode && display_active && char_index == cpos;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            idx_reg <= 8'h00;
        end else if (io_wr && io_sel == 2'b00) begin
            idx_reg <= io_wdata;
        end
    end

    // lock bit 4 exception is ignored: no shadowed field lives there
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 32; i++) rg[i] <= (i == 17) ? 8'h10 : 8'h00;
        end else if (io_wr && io_sel == 2'b01 && idx_reg < 8'h20
                     && !(rg[17][7] && idx_reg <= 8'h07)) begin
            rg[idx_reg[4:0]] <= io_wdata;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_read_answer: assert property (io_rd |=> io_rdata_valid)
        else $error("read not answered on next cycle");
    chk_status_low: assert property
        (io_rd && io_sel == 2'b10 |=> io_rdata[6:0] == 7'h00)
        else $error("status low bits not zero");
    chk_irq_masked: assert property
        (mask_n && $past(mask_n) |-> !retrace_irq)
        else $error("interrupt output high while masked");
    chk_irq_clear: assert property
        (!clear_n && !$past(clear_n) |=> !retrace_irq)
        else $error("interrupt output high while cleared");
    chk_retrace_begin: assert property
        (line_tick && scan_line == vs |=> vretrace)
        else $error("retrace did not start on start line");
    chk_retrace_end: assert property
        (line_tick && scan_line != vs && scan_line[3:0] == wend
         |=> !vretrace)
        else $error("retrace did not end on end line");
    chk_display_window: assert property
        ($past(rst_n, 2) |->
         display_active == ($past(scan_line) <= $past(de)))
        else $error("display window wrong");
    chk_cursor_gfx: assert property (graphics_mode |=> !cursor_hit)
        else $error("cursor shown in graphics mode");
    chk_cursor_addr: assert property
        ($past(rst_n, 2) |-> cursor_addr ==
         $past(screen_base) + {3'b000, $past(cpos), 1'b0})
        else $error("cursor address wrong");
    chk_cursor_hit: assert property
        ($past(rst_n, 2) |-> cursor_hit == $past(hit_cond))
        else $error("cursor hit wrong");

    cover property (line_tick && scan_line == vs);
    cover property (retrace_irq);
    cover property (cursor_hit);
endmodule

// ==== crvt_top_tb_top.sv ====
// self-checking bench for the vertical timing block
module crvt_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [1:0]  io_sel = 2'b11;
    logic        io_wr = 1'b0;
    logic        io_rd = 1'b0;
    logic [7:0]  io_wdata = 8'h00;
    logic [7:0]  io_rdata;
    logic        io_rdata_valid;
    logic        line_tick = 1'b0;
    logic [10:0] scan_line = 11'h000;
    logic        vblank = 1'b0;
    logic        graphics_mode = 1'b0;
    logic [19:0] screen_base = 20'h0_1000;
    logic [15:0] char_index = 16'h0000;
    logic        vretrace, display_active, retrace_irq, cursor_hit;
    logic [19:0] cursor_addr;
    logic [15:0] cp;
    int          num_errors = 0;
    int          comparisons = 0;
    int          cycles = 0;
    // {retrace, active, line}: start 0x5a3, end nibble 7, display end 0x72f
    logic [12:0] tbl [7] = '{13'h09A3, 13'h0DA2, 13'h1DA3, 13'h1DA6,
                             13'h0DA7, 13'h0F2F, 13'h0730};

    crvt_top u_dut (
        .sys_clk, .rst_n, .io_sel, .io_wr, .io_rd, .io_wdata, .io_rdata,
        .io_rdata_valid, .line_tick, .scan_line, .vblank, .graphics_mode,
        .screen_base, .char_index, .vretrace, .display_active,
        .retrace_irq, .cursor_addr, .cursor_hit
    );

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    // whole run is under two hundred cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic close_out();
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [19:0] e, g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic put(input logic [1:0] s, input logic [7:0] d);
        @(negedge sys_clk);
        io_sel = s;
        io_wr = 1'b1;
        io_wdata = d;
        @(negedge sys_clk);
        io_wr = 1'b0;
    endtask

    task automatic wr(input logic [7:0] i, d);
        put(2'b00, i);
        put(2'b01, d);
    endtask

    task automatic rd(input logic [1:0] s, input logic [7:0] i, e,
                      input string n);
        put(2'b00, i);
        io_sel = s;
        io_rd = 1'b1;
        @(negedge sys_clk);
        io_rd = 1'b0;
        chk("valid", 1'b1, io_rdata_valid);
        chk(n, e, io_rdata);
    endtask

    task automatic tick(input logic [10:0] n);
        @(negedge sys_clk);
        scan_line = n;
        line_tick = 1'b1;
        @(negedge sys_clk);
        line_tick = 1'b0;
    endtask

    // blanking rises, status must stay clear until the next line
    task automatic frame();
        @(negedge sys_clk);
        vblank = 1'b0;
        @(negedge sys_clk);
        vblank = 1'b1;
        rd(2'b10, 8'h00, 8'h00, "irq_early");
        tick(11'h5B0);
        @(negedge sys_clk);
    endtask

    initial begin
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        rd(2'b01, 8'h11, 8'h10, "rec_reset");
        rd(2'b01, 8'h20, 8'h00, "unmapped");
        for (int k = 0; k < 2; k++) begin
            cp = k ? 16'h0000 : 16'h1234;
            wr(8'h0E, cp[15:8]);
            wr(8'h0F, cp[7:0]);
            rd(2'b01, 8'h0E, cp[15:8], "cur_high");
            rd(2'b01, 8'h0F, cp[7:0], "cur_low");
            char_index = cp;
            @(negedge sys_clk);
            chk("addr", 20'h0_1000 + {3'b000, cp, 1'b0}, cursor_addr);
            chk("cur_hit", 1'b1, cursor_hit);
            graphics_mode = 1'b1;
            @(negedge sys_clk);
            chk("cur_gfx", 1'b0, cursor_hit);
            graphics_mode = 1'b0;
        end
        wr(8'h07, 8'hFF);
        wr(8'h11, 8'hD0);
        wr(8'h07, 8'h00);
        rd(2'b01, 8'h07, 8'hEF, "ovf_locked");
        rd(2'b01, 8'h11, 8'hD0, "rec_rsv");
        wr(8'h11, 8'h17);
        wr(8'h07, 8'h46);
        wr(8'h1A, 8'h06);
        wr(8'h10, 8'hA3);
        wr(8'h12, 8'h2F);
        for (int k = 0; k < 7; k++) begin
            tick(tbl[k][10:0]);
            chk("vretrace", tbl[k][12], vretrace);
            chk("disp_active", tbl[k][11], display_active);
        end
        frame();
        rd(2'b10, 8'h00, 8'h80, "irq_flag");
        chk("irq_out", 1'b1, retrace_irq);
        wr(8'h11, 8'h37);
        @(negedge sys_clk);
        chk("irq_masked", 1'b0, retrace_irq);
        rd(2'b10, 8'h00, 8'h80, "irq_flag_masked");
        wr(8'h11, 8'h27);
        rd(2'b10, 8'h00, 8'h00, "irq_cleared");
        frame();
        wr(8'h11, 8'h17);
        rd(2'b10, 8'h00, 8'h00, "irq_lost");
        chk("irq_lost_out", 1'b0, retrace_irq);
        frame();
        rd(2'b10, 8'h00, 8'h80, "irq_rearmed");
        chk("irq_rearmed_out", 1'b1, retrace_irq);
        // clearing while the output is high must drop it
        wr(8'h11, 8'h07);
        rd(2'b10, 8'h00, 8'h00, "irq_clear");
        chk("irq_clear_out", 1'b0, retrace_irq);
        close_out();
    end
endmodule

bind crvt_top crvt_top_chk u_chk (
    .sys_clk, .rst_n, .io_sel, .io_wr, .io_rd, .io_wdata, .io_rdata,
    .io_rdata_valid, .line_tick, .scan_line, .vblank, .graphics_mode,
    .screen_base, .char_index, .vretrace, .display_active,
    .retrace_irq, .cursor_addr, .cursor_hit
);
